// ==== core/sop_pkg.sv ====
// System options and part number register bank: constants, types and field layout
// Operation
// - Options one takes only first write after reset
// - Options one always reads its current contents
// - Bit 7 enables watchdog; timeout forces reset
// - Bit 6 selects short or long watchdog timeout
// - Bit 5 allows halt; else halt forces reset
// - Bit 1 gives shared pin to debug; set
// - Bit 0 gives shared pin to reset input
// - Reset pin enable cleared by power-on, not by system reset
// - Options two bit 7: write-once watchdog clock select
// - Options two bit 4 enables serial port filter
// - Options two bit 3 selects serial port pins
// - Comparator two route feeds timer two channel 0
// - Options two bit 1 selects two-wire pins
// - Options two bit 0 routes comparator one
// - Write-once bit 7 of options two locks after first
// - Part number upper bits in high register 3:0
// - High register bits 7:4 reserved, ignore writes
// - Low register returns part number bits 7:0
package sop_pkg;

  // Word-aligned byte addresses on the bus
  localparam logic [7:0] ADDR_OPTIONS_ONE = 8'h00;
  localparam logic [7:0] ADDR_OPTIONS_TWO = 8'h04;
  localparam logic [7:0] ADDR_PART_HIGH   = 8'h08;
  localparam logic [7:0] ADDR_PART_LOW    = 8'h0C;

  // Options one fields
  localparam int BIT_WATCHDOG_ENABLE       = 7;
  localparam int BIT_WATCHDOG_LONG_TIMEOUT = 6;
  localparam int BIT_HALT_MODE_ALLOW       = 5;
  localparam int BIT_DEBUG_PIN_ENABLE      = 1;
  localparam int BIT_RESET_PIN_ENABLE      = 0;
  localparam logic [7:0] OPTIONS_ONE_MASK  = 8'hE3;
  localparam logic [7:0] OPTIONS_ONE_RESET = 8'hC2;

  // Options two fields
  localparam int BIT_WATCHDOG_CLOCK_SELECT     = 7;
  localparam int BIT_SERIAL_PORT_FILTER_ENABLE = 4;
  localparam int BIT_SERIAL_PORT_PIN_SELECT    = 3;
  localparam int BIT_COMPARATOR2_CAPTURE_ROUTE = 2;
  localparam int BIT_TWO_WIRE_PIN_SELECT       = 1;
  localparam int BIT_COMPARATOR1_CAPTURE_ROUTE = 0;
  localparam logic [7:0] OPTIONS_TWO_MASK      = 8'h9F;
  localparam logic [7:0] OPTIONS_TWO_RESET     = 8'h00;

  // Part number layout
  localparam logic [3:0] PART_HIGH_RESERVED = 4'h0;

  typedef struct packed {
    logic watchdog_enable;
    logic watchdog_long_timeout;
    logic watchdog_clock_select;
    logic halt_mode_allow;
    logic debug_pin_enable;
    logic reset_pin_enable;
    logic reset_pin_pullup;
    logic serial_port_filter_enable;
    logic serial_port_pin_select;
    logic two_wire_pin_select;
    logic comparator1_capture_route;
    logic comparator2_capture_route;
  } sop_cfg_t;

endpackage : sop_pkg

// ==== core/sop_regs.sv ====
// System options and part number register bank behind a classic Wishbone slave
//
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module sop_regs
  import sop_pkg::*;
#(
  // Arbitrary neutral value
  parameter logic [11:0] PART_NUMBER = 12'hA5C
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        sys_reset_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        watchdog_timeout_in,
  input  wire logic        halt_exec_in,
  input  wire logic        comparator1_in,
  input  wire logic        comparator2_in,
  input  wire logic        timer1_ch0_pin_in,
  input  wire logic        timer2_ch0_pin_in,
  output logic             timer1_ch0_out,
  output logic             timer2_ch0_out,
  output logic             watchdog_reset_out,
  output logic             illegal_halt_reset_out,
  output logic             halt_enter_out,
  output sop_cfg_t         cfg_out
);

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic [7:0] options_one;
  logic [7:0] options_two;
  logic       options_one_used;
  logic       options_two_used;
  logic       ack;
  logic       bus_req;
  logic       wr_take;
  logic       next_ack;

  assign bus_req  = wb_cyc_in & wb_stb_in;
  assign next_ack = bus_req & ~ack;
  // Write lands on the edge where the master sees ack
  assign wr_take  = bus_req & ack & wb_we_in & wb_sel_in[0];
  assign wb_ack_out = ack;

  function automatic logic [7:0] read_mux(input logic [7:0] adr);
    logic [7:0] v;
    v = 8'h00;
    case (adr)
      ADDR_OPTIONS_ONE: v = options_one & OPTIONS_ONE_MASK;
      ADDR_OPTIONS_TWO: v = options_two & OPTIONS_TWO_MASK;
      ADDR_PART_HIGH:   v = {PART_HIGH_RESERVED, PART_NUMBER[11:8]};
      ADDR_PART_LOW:    v = PART_NUMBER[7:0];
      default:          v = 8'h00;
    endcase
    return v;
  endfunction : read_mux

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack <= 1'b0;
    end else begin
      ack <= next_ack;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (next_ack) begin
      wb_dat_out <= {24'h00_0000, read_mux(wb_adr_in)};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Options one: whole register write-once

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      options_one_used <= 1'b0;
    end else if (sys_reset_in) begin
      options_one_used <= 1'b0;
    end else if (wr_take && wb_adr_in == ADDR_OPTIONS_ONE) begin
      options_one_used <= 1'b1;
    end
  end

  // Upper bits return to defaults on any reset
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      options_one[7:1] <= OPTIONS_ONE_RESET[7:1];
    end else if (sys_reset_in) begin
      options_one[7:1] <= OPTIONS_ONE_RESET[7:1];
    end else if (wr_take && wb_adr_in == ADDR_OPTIONS_ONE && !options_one_used) begin
      options_one[7:1] <= wb_dat_in[7:1] & OPTIONS_ONE_MASK[7:1];
    end
  end

  // Reset pin enable survives non power-on resets
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      options_one[0] <= OPTIONS_ONE_RESET[0];
    end else if (wr_take && wb_adr_in == ADDR_OPTIONS_ONE && !options_one_used && !sys_reset_in) begin
      options_one[0] <= wb_dat_in[BIT_RESET_PIN_ENABLE];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Options two: clock select write-once, bits 4:0 plain read/write, bits 6:5 read as zero

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      options_two_used <= 1'b0;
    end else if (sys_reset_in) begin
      options_two_used <= 1'b0;
    end else if (wr_take && wb_adr_in == ADDR_OPTIONS_TWO) begin
      options_two_used <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      options_two <= OPTIONS_TWO_RESET;
    end else if (sys_reset_in) begin
      options_two <= OPTIONS_TWO_RESET;
    end else if (wr_take && wb_adr_in == ADDR_OPTIONS_TWO) begin
      if (!options_two_used) begin
        options_two[BIT_WATCHDOG_CLOCK_SELECT] <= wb_dat_in[BIT_WATCHDOG_CLOCK_SELECT];
      end
      options_two[6:0] <= wb_dat_in[6:0] & OPTIONS_TWO_MASK[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration outputs

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_out <= '0;
    end else begin
      cfg_out.watchdog_enable           <= options_one[BIT_WATCHDOG_ENABLE];
      cfg_out.watchdog_long_timeout     <= options_one[BIT_WATCHDOG_LONG_TIMEOUT];
      cfg_out.watchdog_clock_select     <= options_two[BIT_WATCHDOG_CLOCK_SELECT];
      cfg_out.halt_mode_allow           <= options_one[BIT_HALT_MODE_ALLOW];
      cfg_out.debug_pin_enable          <= options_one[BIT_DEBUG_PIN_ENABLE];
      cfg_out.reset_pin_enable          <= options_one[BIT_RESET_PIN_ENABLE];
      cfg_out.reset_pin_pullup          <= options_one[BIT_RESET_PIN_ENABLE];
      cfg_out.serial_port_filter_enable <= options_two[BIT_SERIAL_PORT_FILTER_ENABLE];
      cfg_out.serial_port_pin_select    <= options_two[BIT_SERIAL_PORT_PIN_SELECT];
      cfg_out.two_wire_pin_select       <= options_two[BIT_TWO_WIRE_PIN_SELECT];
      cfg_out.comparator1_capture_route <= options_two[BIT_COMPARATOR1_CAPTURE_ROUTE];
      cfg_out.comparator2_capture_route <= options_two[BIT_COMPARATOR2_CAPTURE_ROUTE];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset requests and capture routing

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      watchdog_reset_out <= 1'b0;
    end else begin
      watchdog_reset_out <= watchdog_timeout_in & options_one[BIT_WATCHDOG_ENABLE];
    end
  end

  // Halt is either entered or turned into an illegal-opcode reset
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      illegal_halt_reset_out <= 1'b0;
      halt_enter_out         <= 1'b0;
    end else begin
      illegal_halt_reset_out <= halt_exec_in & ~options_one[BIT_HALT_MODE_ALLOW];
      halt_enter_out         <= halt_exec_in & options_one[BIT_HALT_MODE_ALLOW];
    end
  end

  // Route off leaves the timer on its own pin
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      timer1_ch0_out <= 1'b0;
      timer2_ch0_out <= 1'b0;
    end else begin
      timer1_ch0_out <= options_two[BIT_COMPARATOR1_CAPTURE_ROUTE] ? comparator1_in : timer1_ch0_pin_in;
      timer2_ch0_out <= options_two[BIT_COMPARATOR2_CAPTURE_ROUTE] ? comparator2_in : timer2_ch0_pin_in;
    end
  end

endmodule : sop_regs

// ==== tb/sop_regs_checker.sv ====
// Assertions on the option bank ports
`timescale 1ns/1ps
module sop_regs_checker
  import sop_pkg::*;
#(
  parameter logic [11:0] PART_NUMBER = 12'hA5C
) (
  input wire logic        core_clk_in,
  input wire logic        rst_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        watchdog_timeout_in,
  input wire logic        halt_exec_in,
  input wire logic        comparator1_in,
  input wire logic        comparator2_in,
  input wire logic        timer1_ch0_pin_in,
  input wire logic        timer2_ch0_pin_in,
  input wire logic        timer1_ch0_out,
  input wire logic        timer2_ch0_out,
  input wire logic        watchdog_reset_out,
  input wire logic        illegal_halt_reset_out,
  input wire logic        halt_enter_out,
  input wire sop_cfg_t    cfg_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  wire logic rd = wb_ack_out && !wb_we_in;
  ////////////////////////////////////////
  ack_answer_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack late");
  ack_single_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack stuck");
  watchdog_force_a: assert property (watchdog_reset_out == ($past(watchdog_timeout_in) && cfg_out.watchdog_enable))
    else $error("watchdog reset wrong");
  halt_illegal_a: assert property (illegal_halt_reset_out == ($past(halt_exec_in) && !cfg_out.halt_mode_allow))
    else $error("illegal halt wrong");
  halt_enter_a: assert property (halt_enter_out == ($past(halt_exec_in) && cfg_out.halt_mode_allow))
    else $error("halt entry wrong");
  timer_one_a: assert property (timer1_ch0_out == (cfg_out.comparator1_capture_route ?
    $past(comparator1_in) : $past(timer1_ch0_pin_in))) else $error("timer one route wrong");
  timer_two_a: assert property (timer2_ch0_out == (cfg_out.comparator2_capture_route ?
    $past(comparator2_in) : $past(timer2_ch0_pin_in))) else $error("timer two route wrong");
  pullup_follow_a: assert property (cfg_out.reset_pin_pullup == cfg_out.reset_pin_enable)
    else $error("pullup wrong");
  part_high_a: assert property (rd && wb_adr_in == ADDR_PART_HIGH |-> wb_dat_out[3:0] == PART_NUMBER[11:8])
    else $error("part high wrong");
  part_low_a: assert property (rd && wb_adr_in == ADDR_PART_LOW |-> wb_dat_out[7:0] == PART_NUMBER[7:0])
    else $error("part low wrong");
  opt_unused_a: assert property (rd && wb_adr_in == ADDR_OPTIONS_ONE |-> wb_dat_out[4:2] == 3'h0)
    else $error("unused bits set");
  cover property (wb_ack_out && wb_we_in);
  cover property (watchdog_reset_out);
  cover property (illegal_halt_reset_out);
endmodule : sop_regs_checker
bind sop_regs sop_regs_checker #(.PART_NUMBER(PART_NUMBER)) chk_u (.*);

// ==== tb/sop_regs_bench.sv ====
// Self-checking bench for the option bank
`timescale 1ns/1ps
module sop_regs_bench;
  import sop_pkg::*;
  localparam logic [11:0] PN = 12'h3B7;
  logic core_clk_in = 0, rst_in = 1, sys_reset_in = 0;
  logic wb_cyc_in = 0, wb_stb_in = 0, wb_we_in = 0;
  logic [7:0] wb_adr_in = 8'h00;
  logic [3:0] wb_sel_in = 4'hF;
  logic [31:0] wb_dat_in = 32'h0, wb_dat_out, q;
  logic watchdog_timeout_in = 0, halt_exec_in = 0, comparator1_in = 0;
  logic comparator2_in = 0, timer1_ch0_pin_in = 0, timer2_ch0_pin_in = 0;
  logic wb_ack_out, timer1_ch0_out, timer2_ch0_out;
  logic watchdog_reset_out, illegal_halt_reset_out, halt_enter_out;
  sop_cfg_t cfg_out;
  int mismatches = 0, checked = 0, cycles = 0;
  wire logic [4:0] outs = {timer1_ch0_out, timer2_ch0_out, watchdog_reset_out,
                           illegal_halt_reset_out, halt_enter_out};
  sop_regs #(.PART_NUMBER(PN)) dut_u (.*);
  initial forever #5 core_clk_in = ~core_clk_in;
  ////////////////////////////////////////
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= w;
    wb_adr_in <= a;
    wb_dat_in <= d;
    do @(posedge core_clk_in); while (wb_ack_out !== 1'b1);
    q = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask : bus
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : cmp
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp($sformatf("reg %h", a), e, q);
  endtask : rdc
  // Inputs held two edges so registered outputs have settled
  task automatic pins(input logic [5:0] v, input logic [4:0] e);
    @(posedge core_clk_in);
    {watchdog_timeout_in, halt_exec_in, comparator1_in, comparator2_in,
     timer1_ch0_pin_in, timer2_ch0_pin_in} <= v;
    repeat (2) @(posedge core_clk_in);
    cmp("outs", {27'h0, e}, {27'h0, outs});
  endtask : pins
  task automatic summarize();
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      summarize();
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    rdc(ADDR_OPTIONS_ONE, 32'hC2);
    rdc(ADDR_OPTIONS_TWO, 32'h00);
    rdc(ADDR_PART_HIGH, {PART_HIGH_RESERVED, PN[11:8]});
    rdc(ADDR_PART_LOW, PN[7:0]);
    rdc(8'h10, 32'h0);
    bus(1'b1, ADDR_OPTIONS_ONE, 32'h3D);
    rdc(ADDR_OPTIONS_ONE, 32'h21);
    cmp("cfg", 32'h160, {20'h0, cfg_out});
    bus(1'b1, ADDR_OPTIONS_ONE, 32'hC2);
    rdc(ADDR_OPTIONS_ONE, 32'h21);
    bus(1'b1, ADDR_PART_HIGH, 32'hFF);
    rdc(ADDR_PART_HIGH, {PART_HIGH_RESERVED, PN[11:8]});
    bus(1'b1, ADDR_OPTIONS_TWO, 32'hFF);
    rdc(ADDR_OPTIONS_TWO, 32'h9F);
    cmp("cfg", 32'h37F, {20'h0, cfg_out});
    pins(6'b111100, 5'b11001);
    bus(1'b1, ADDR_OPTIONS_TWO, 32'h1A);
    rdc(ADDR_OPTIONS_TWO, 32'h9A);
    pins(6'b001100, 5'b00000);
    @(posedge core_clk_in);
    sys_reset_in <= 1'b1;
    @(posedge core_clk_in);
    sys_reset_in <= 1'b0;
    rdc(ADDR_OPTIONS_ONE, 32'hC3);
    rdc(ADDR_OPTIONS_TWO, 32'h00);
    cmp("cfg", 32'hCE0, {20'h0, cfg_out});
    pins(6'b100000, 5'b00100);
    pins(6'b010000, 5'b00010);
    pins(6'b000000, 5'b00000);
    bus(1'b1, ADDR_OPTIONS_ONE, 32'h00);
    rdc(ADDR_OPTIONS_ONE, 32'h00);
    @(posedge core_clk_in);
    rst_in <= 1'b1;
    @(posedge core_clk_in);
    rst_in <= 1'b0;
    rdc(ADDR_OPTIONS_ONE, 32'hC2);
    summarize();
  end
endmodule : sop_regs_bench
